// File: core/cpu_local_bus_cycle_unit.sv
// Local bus cycle sequencer: T1..T4 with waits, both strap modes.
// Assumes the core gives one request at a time and holds it until ack.
`timescale 1ns/1ps
`include "bus_cycle_regs.svh"
module cpu_local_bus_cycle_unit (
    input wire logic clk_i,           // Processor clock, 25 MHz.
    input wire logic rst_i,           // Asynchronous reset, high.
    input wire logic mode_strap_i,    // High minimum, low maximum.
    input wire logic req_i,           // Core wants a bus cycle.
    input wire logic [2:0] kind_i,    // Cycle kind code.
    input wire logic [15:0] addr_i,   // Byte address.
    input wire logic word_i,          // Whole word transfer.
    input wire logic [15:0] wdata_i,  // Write data, byte in low half.
    input wire logic last_i,          // Last cycle of instruction.
    output logic ack_o,               // Request taken this cycle.
    output logic done_o,              // Cycle in T4.
    output logic [15:0] rdata_o,      // Read data, byte in low half.
    output logic [9:0] vector_o,      // Vector table pointer.
    output logic vector_valid_o,      // Vector pointer updated.
    input wire logic lock_prefix_i,   // Lock prefix decoded, pulse.
    output logic lock_n_o,            // Bus lock, low active.
    input wire logic request_grant_i, // Other master asks for bus.
    output logic request_grant_o,     // Bus handed over.
    input wire logic wait_active_i,   // Core executing wait.
    input wire logic test_n_i,        // Test input, low active.
    input wire logic queue_full_i,    // Prefetch queue full.
    input wire logic intr_i,          // Interrupt request.
    input wire logic int_enable_i,    // Interrupts enabled.
    output logic wait_done_o,         // Wait may end.
    output logic refetch_wait_o,      // Refetch wait, pulse.
    input wire logic ready_i,         // Target ready.
    output logic address_latch_strobe_o, // Address strobe.
    output logic [15:0] multiplexed_bus_o, // Bus output value.
    input wire logic [15:0] multiplexed_bus_i, // Bus input value.
    output logic multiplexed_bus_oe_n_o, // Bus enable, low drives.
    output logic memory_or_io_select_o, // High memory, low I/O.
    output logic read_strobe_n_o,     // Read strobe, low active.
    output logic store_strobe_n_o,    // Write strobe, low active.
    output logic interrupt_ack_n_o,   // Acknowledge, low active.
    output logic high_byte_enable_n_o, // High lane enable, low.
    output logic transceiver_direction_o, // High transmit.
    output logic transceiver_output_enable_n_o, // Low enables.
    output logic [2:0] cycle_status_o, // Coded cycle status.
    output logic ctl_oe_n_o           // Control pins enable, low.
);
    bus_cycle_pkg::bus_state_e state_r, state_nxt;
    bus_cycle_pkg::cycle_kind_e kind_r, kind_nxt;
    logic [15:0] addr_r, wdata_r, bus_r, rdata_r;
    logic [9:0] vector_r;
    logic word_r, last_r, second_r, auto_r, int_wait_r;
    logic mode_min_r, strap_done_r, vec_valid_r;
    logic start_user, load, strobe, in_cyc, ready_edge;
    logic is_rd, is_wr, is_interrupt_ack, is_mem, min_mode;
    logic [15:0] wr_lanes, rd_lanes;
    arb_if a ();

    lock_arbiter u_arb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .a(a.arb)
    );

    // The strap is caught once, on the first edge after reset ends.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_min_r <= `MODE_MIN_RST;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            mode_min_r <= mode_strap_i; // see R8
            strap_done_r <= 1'b1;
        end
    end
    assign min_mode = mode_min_r;

    // Kind decode of the cycle in flight.
    assign is_rd = kind_r inside {bus_cycle_pkg::K_CODE,
        bus_cycle_pkg::K_MRD, bus_cycle_pkg::K_IORD};
    assign is_wr = kind_r inside {bus_cycle_pkg::K_MWR,
        bus_cycle_pkg::K_IOWR};
    assign is_interrupt_ack = kind_r == bus_cycle_pkg::K_INTERRUPT_ACK;
    assign is_mem = kind_r inside {bus_cycle_pkg::K_CODE,
        bus_cycle_pkg::K_MRD, bus_cycle_pkg::K_MWR};
    assign strobe = state_r inside {bus_cycle_pkg::S_T2,
        bus_cycle_pkg::S_T3, bus_cycle_pkg::S_TW};
    assign in_cyc = strobe || state_r == bus_cycle_pkg::S_T1 ||
        state_r == bus_cycle_pkg::S_T4;
    assign ready_edge = ready_i && (state_r == bus_cycle_pkg::S_T3 ||
        state_r == bus_cycle_pkg::S_TW);

    // Fetches stop while a wait spins on a full queue.
    assign start_user = req_i && !(wait_active_i && queue_full_i && // see R5
        bus_cycle_pkg::cycle_kind_e'(kind_i) == bus_cycle_pkg::K_CODE);
    assign load = state_r == bus_cycle_pkg::S_IDLE && !a.want &&
        (int_wait_r || start_user);
    assign ack_o = load && !int_wait_r;
    assign kind_nxt = int_wait_r ? bus_cycle_pkg::K_INTERRUPT_ACK :
        bus_cycle_pkg::cycle_kind_e'(kind_i);

    // Sequencer; a pending grant outranks a new cycle when idle.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            bus_cycle_pkg::S_IDLE: begin
                if (a.want) begin
                    state_nxt = bus_cycle_pkg::S_HOLD;
                end else if (load) begin
                    state_nxt = bus_cycle_pkg::S_T1; // see R9
                end
            end
            bus_cycle_pkg::S_T1: begin
                state_nxt = (kind_r == bus_cycle_pkg::K_HALT) ?
                    bus_cycle_pkg::S_T4 : bus_cycle_pkg::S_T2;
            end
            bus_cycle_pkg::S_T2: begin
                state_nxt = bus_cycle_pkg::S_T3;
            end
            bus_cycle_pkg::S_T3, bus_cycle_pkg::S_TW: begin
                state_nxt = ready_i ? bus_cycle_pkg::S_T4 :
                    bus_cycle_pkg::S_TW; // see R20
            end
            bus_cycle_pkg::S_T4: begin
                state_nxt = (is_interrupt_ack && !second_r) ?
                    bus_cycle_pkg::S_T1 : bus_cycle_pkg::S_IDLE; // see R18
            end
            bus_cycle_pkg::S_HOLD: begin
                if (!request_grant_i) begin
                    state_nxt = bus_cycle_pkg::S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= bus_cycle_pkg::S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Request fields are held for the whole cycle or acknowledge pair.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            kind_r <= bus_cycle_pkg::K_CODE;
            addr_r <= `BUS_RST;
            wdata_r <= `BUS_RST;
            word_r <= 1'b0;
            last_r <= 1'b0;
            auto_r <= 1'b0;
        end else if (load) begin
            kind_r <= kind_nxt;
            addr_r <= addr_i;
            wdata_r <= wdata_i;
            word_r <= word_i;
            last_r <= last_i;
            auto_r <= int_wait_r;
        end
    end

    // Marks the second of the two acknowledge cycles.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            second_r <= 1'b0;
        end else if (state_r == bus_cycle_pkg::S_T4 && is_interrupt_ack) begin
            second_r <= !second_r; // see R18
        end
    end

    // An interrupt seen while a wait is held off the bus is kept until
    // the bus comes back; set and clear happen in different states.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_wait_r <= 1'b0;
        end else if (state_r == bus_cycle_pkg::S_HOLD && wait_active_i &&
                     intr_i && int_enable_i) begin
            int_wait_r <= 1'b1; // see R7
        end else if (load) begin
            int_wait_r <= 1'b0;
        end
    end

    // Even bytes use the low lanes, odd bytes the high lanes.
    assign wr_lanes = word_r ? wdata_r : (addr_r[0] ?
        {wdata_r[7:0], 8'h00} : {8'h00, wdata_r[7:0]}); // see R16
    assign rd_lanes = word_r ? multiplexed_bus_i : (addr_r[0] ?
        {8'h00, multiplexed_bus_i[15:8]} :
        {8'h00, multiplexed_bus_i[7:0]}); // see R16

    // Address goes out in T1, write data replaces it from T2.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_r <= `BUS_RST;
        end else if (load) begin
            bus_r <= addr_i; // see R9
        end else if (state_r == bus_cycle_pkg::S_T1) begin
            bus_r <= wr_lanes; // see R13
        end
    end

    // Read data and the type byte are taken on the ready edge.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= `BUS_RST;
            vector_r <= 10'h000;
            vec_valid_r <= 1'b0;
        end else begin
            vec_valid_r <= 1'b0;
            if (ready_edge && is_rd) begin
                rdata_r <= rd_lanes;
            end
            if (ready_edge && is_interrupt_ack && second_r) begin
                vector_r <= {multiplexed_bus_i[7:0],
                    `VEC_ZERO_BITS}; // see R19
                vec_valid_r <= 1'b1;
            end
        end
    end

    assign a.lock_prefix = lock_prefix_i;
    assign a.cycle_end = state_r == bus_cycle_pkg::S_T4;
    assign a.last_cycle = last_r;
    assign a.in_hold = state_r == bus_cycle_pkg::S_HOLD;
    assign a.rq = request_grant_i;
    assign lock_n_o = !a.locked; // see R1
    assign request_grant_o = a.grant; // see R3
    assign ctl_oe_n_o = state_r == bus_cycle_pkg::S_HOLD; // see R6
    assign wait_done_o = wait_active_i && !test_n_i; // see R4
    assign refetch_wait_o = state_r == bus_cycle_pkg::S_T4 && is_interrupt_ack &&
        second_r && auto_r; // see R7
    assign done_o = state_r == bus_cycle_pkg::S_T4;
    assign rdata_o = rdata_r;
    assign vector_o = vector_r;
    assign vector_valid_o = vec_valid_r;

    // Pin decode; acknowledge cycles never drive the multiplexed bus.
    assign address_latch_strobe_o = state_r == bus_cycle_pkg::S_T1;
    assign multiplexed_bus_o = bus_r;
    assign multiplexed_bus_oe_n_o = !((state_r == bus_cycle_pkg::S_T1 &&
        !is_interrupt_ack) || (is_wr && in_cyc)); // see R11
    assign memory_or_io_select_o = in_cyc && is_mem; // see R10
    assign read_strobe_n_o = !(min_mode && is_rd && strobe); // see R11
    assign store_strobe_n_o = !(min_mode && is_wr && strobe); // see R14
    assign interrupt_ack_n_o = !(min_mode && is_interrupt_ack && strobe); // see R17
    assign high_byte_enable_n_o = !(word_r || addr_r[0]); // see R15
    assign transceiver_direction_o = !(in_cyc && (is_rd || is_interrupt_ack));
    assign transceiver_output_enable_n_o = !(strobe ||
        (is_wr && state_r == bus_cycle_pkg::S_T4));

    // Status drops to inactive in the state that leads into T4, except in the T1 of a halt cycle.
    always_comb begin
        cycle_status_o = `ST_INACTIVE; // see R22
        if (!min_mode && (state_r == bus_cycle_pkg::S_T1 ||
            state_r == bus_cycle_pkg::S_T2 || (strobe && !ready_edge))) begin
            unique case (kind_r) // see R21
                bus_cycle_pkg::K_CODE: cycle_status_o = `ST_CODE;
                bus_cycle_pkg::K_MRD: cycle_status_o = `ST_MRD;
                bus_cycle_pkg::K_MWR: cycle_status_o = `ST_MWR;
                bus_cycle_pkg::K_IORD: cycle_status_o = `ST_IORD;
                bus_cycle_pkg::K_IOWR: cycle_status_o = `ST_IOWR;
                bus_cycle_pkg::K_INTERRUPT_ACK: cycle_status_o = `ST_INTERRUPT_ACK;
                bus_cycle_pkg::K_HALT: cycle_status_o = `ST_HALT;
            endcase
        end
    end

    chk_strobe_addr_t1: assert property (@(posedge clk_i) disable iff
        (rst_i) state_r == bus_cycle_pkg::S_IDLE && load ##1 !is_interrupt_ack
        |-> address_latch_strobe_o && !multiplexed_bus_oe_n_o &&
        multiplexed_bus_o == $past(addr_i)) // see R9
        else $error("T1 lacks address or strobe.");
    chk_mio_steady: assert property (@(posedge clk_i) disable iff
        (rst_i) in_cyc && state_r != bus_cycle_pkg::S_T1
        |-> $stable(memory_or_io_select_o)) // see R10
        else $error("Memory select moved mid cycle.");
    chk_read_float_t2: assert property (@(posedge clk_i) disable iff
        (rst_i) state_r == bus_cycle_pkg::S_T1 && is_rd && min_mode
        |=> multiplexed_bus_oe_n_o && !read_strobe_n_o) // see R11
        else $error("Read T2 bus or strobe wrong.");
    chk_write_data_hold: assert property (@(posedge clk_i) disable iff
        (rst_i) state_r == bus_cycle_pkg::S_T2 && is_wr
        |-> !multiplexed_bus_oe_n_o throughout
        (##[1:300] state_r == bus_cycle_pkg::S_T4)) // see R13
        else $error("Write data dropped before T4.");
    chk_store_strobe: assert property (@(posedge clk_i) disable iff
        (rst_i) is_wr && min_mode && strobe |-> !store_strobe_n_o ##0
        (state_r != bus_cycle_pkg::S_T4)) // see R14
        else $error("Store strobe missing.");
    chk_byte_lanes: assert property (@(posedge clk_i) disable iff
        (rst_i) in_cyc && !word_r && !addr_r[0]
        |-> high_byte_enable_n_o) // see R15
        else $error("High lane enabled for even byte.");
    chk_interrupt_ack_bus_idle: assert property (@(posedge clk_i) disable iff
        (rst_i) in_cyc && is_interrupt_ack |-> multiplexed_bus_oe_n_o) // see R18
        else $error("Bus driven in acknowledge.");
    chk_wait_on_ready: assert property (@(posedge clk_i) disable iff
        (rst_i) state_r == bus_cycle_pkg::S_T3 && !ready_i
        |=> state_r == bus_cycle_pkg::S_TW) // see R20
        else $error("No wait state inserted.");
    chk_status_early: assert property (@(posedge clk_i) disable iff
        (rst_i) state_r == bus_cycle_pkg::S_T4 && $past(strobe)
        |-> $past(cycle_status_o) == `ST_INACTIVE) // see R22
        else $error("Status active just before T4.");
    chk_float_hold: assert property (@(posedge clk_i) disable iff
        (rst_i) request_grant_o |-> ctl_oe_n_o &&
        multiplexed_bus_oe_n_o) // see R6
        else $error("Outputs driven while granted.");
    chk_no_fetch_full: assert property (@(posedge clk_i) disable iff
        (rst_i) wait_active_i && queue_full_i && ack_o
        |-> kind_i != 3'h0) // see R5
        else $error("Fetch issued on full queue.");
    chk_max_no_strobe: assert property (@(posedge clk_i) disable iff
        (rst_i) !min_mode |-> read_strobe_n_o && store_strobe_n_o)
        // see R8
        else $error("Strobes driven in maximum mode.");
    cov_read_wait: cover property (@(posedge clk_i) disable iff (rst_i)
        state_r == bus_cycle_pkg::S_TW && is_rd ##1
        state_r == bus_cycle_pkg::S_T4);
    cov_interrupt_ack_pair: cover property (@(posedge clk_i) disable iff (rst_i)
        vec_valid_r);
    cov_hold_grant: cover property (@(posedge clk_i) disable iff (rst_i)
        request_grant_o && wait_active_i);
    cov_wait_refetch: cover property (@(posedge clk_i) disable iff (rst_i)
        refetch_wait_o);
endmodule

// File: core/bus_cycle_regs.svh
// Constants of the local bus cycle unit: cycle status codes and resets.
// Assumes one clock, each bus state lasting one clock period.
// Contract
// R1 - Lock output goes low after prefix decode.
// R2 - Lock releases after last cycle of instruction.
// R3 - Request during lock is recorded, granted later.
// R4 - Wait repeats until test input is low.
// R5 - Waiting with full queue issues no fetches.
// R6 - Bus request during wait floats all outputs.
// R7 - Interrupt during wait serviced after bus regained.
// R8 - Strap high gives strobes, low gives status.
// R9 - Every cycle starts in T1 with address strobe.
// R10 - Memory or I/O select holds T1 through T4.
// R11 - Read floats address and strobes from T2.
// R12 - Target drives data and ready during read.
// R13 - Write data driven from T2 until T4.
// R14 - Store strobe active T2, T3 and waits.
// R15 - High enable and address bit choose lanes.
// R16 - Even bytes low lanes, odd bytes high.
// R17 - Acknowledge uses read timing, no address.
// R18 - Two acknowledge cycles, bus left inactive.
// R19 - Type byte times four gives vector pointer.
// R20 - Ready sampled, wait states while it is low.
// R21 - Maximum mode status encodes the cycle type.
// R22 - Status goes inactive in state before T4; halt cycles keep it active in T1.
`ifndef BUS_CYCLE_REGS_SVH
`define BUS_CYCLE_REGS_SVH
`define ST_INTERRUPT_ACK 3'h0
`define ST_IORD 3'h1
`define ST_IOWR 3'h2
`define ST_HALT 3'h3
`define ST_CODE 3'h4
`define ST_MRD 3'h5
`define ST_MWR 3'h6
`define ST_INACTIVE 3'h7
`define BUS_RST 16'h0000
`define VEC_ZERO_BITS 2'h0
`define MODE_MIN_RST 1'h1
`endif

// File: core/bus_cycle_pkg.sv
// Types used by the bus cycle unit only: cycle kinds and bus states.
// Assumes the constants header is included where codes are needed.
package bus_cycle_pkg;
    typedef enum logic [2:0] {
        K_CODE, K_MRD, K_MWR, K_IORD, K_IOWR, K_INTERRUPT_ACK, K_HALT
    } cycle_kind_e;
    typedef enum logic [2:0] {
        S_IDLE, S_T1, S_T2, S_T3, S_TW, S_T4, S_HOLD
    } bus_state_e;
endpackage

// File: core/arb_if.sv
// Signals between the bus sequencer and the lock arbiter.
// Assumes both ends share the sequencer clock.
`timescale 1ns/1ps
interface arb_if;
    logic lock_prefix;
    logic cycle_end;
    logic last_cycle;
    logic in_hold;
    logic rq;
    logic locked;
    logic want;
    logic grant;
    modport core (output lock_prefix, cycle_end, last_cycle, in_hold, rq,
                  input locked, want, grant);
    modport arb (input lock_prefix, cycle_end, last_cycle, in_hold, rq,
                 output locked, want, grant);
endinterface

// File: core/lock_arbiter.sv
// Bus lock and request/grant deferral for the local bus.
// Assumes the sequencer reports cycle ends and the hold state.
`timescale 1ns/1ps
module lock_arbiter (
    input wire logic clk_i, // Processor clock.
    input wire logic rst_i, // Asynchronous reset, active high.
    arb_if.arb a            // Link to the sequencer.
);
    logic locked_r;
    logic pend_r;
    logic grant_r;

    // Lock rises the cycle after the prefix; a new prefix beats release.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            locked_r <= 1'b0;
        end else if (a.lock_prefix) begin
            locked_r <= 1'b1; // see R1
        end else if (a.cycle_end && a.last_cycle) begin
            locked_r <= 1'b0; // see R2
        end
    end

    // A request is remembered until the hold state takes it over.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
        end else if (a.rq && !grant_r && !a.in_hold) begin
            pend_r <= 1'b1; // see R3
        end else if (a.in_hold) begin
            pend_r <= 1'b0;
        end
    end

    // Grant only inside the hold state, so it never overlaps a cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            grant_r <= 1'b0;
        end else begin
            grant_r <= a.in_hold && a.rq;
        end
    end

    assign a.locked = locked_r;
    assign a.want = pend_r && !locked_r; // see R3
    assign a.grant = grant_r;

    chk_lock_after_prefix: assert property (@(posedge clk_i) disable iff
        (rst_i) a.lock_prefix |=> locked_r) // see R1
        else $error("Lock did not follow prefix.");
    chk_lock_release: assert property (@(posedge clk_i) disable iff
        (rst_i) a.cycle_end && a.last_cycle && !a.lock_prefix
        |=> !locked_r) // see R2
        else $error("Lock not released after last cycle.");
    chk_no_grant_locked: assert property (@(posedge clk_i) disable iff
        (rst_i) locked_r |-> !a.want) // see R3
        else $error("Request honoured while locked.");
endmodule

// File: test/bus_target_model.sv
// Far side model: memory, ports and interrupt controller on the bus.
// Assumes the transceiver enable marks T2, T3 and every wait state.
`timescale 1ns/1ps
module bus_target_model (
    input wire logic clk_i,          // Processor clock.
    input wire logic rst_i,          // Reset, active high.
    input wire logic [3:0] waits_i,  // Wait states to insert.
    input wire logic den_n_i,        // Transceiver enable, low.
    input wire logic dir_i,          // Low while reading.
    input wire logic [15:0] data_i,  // Read data or type byte.
    output logic ready_o,            // Target ready.
    output logic [15:0] bus_o        // Value the target puts on the bus.
);
    logic [3:0] cnt_r;
    logic [15:0] last_r;
    // Count strobed cycles so a slow target holds ready low long enough.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            cnt_r <= 4'h0;
        else
            cnt_r <= den_n_i ? 4'h0 : cnt_r + 4'h1;
    end
    assign ready_o = !den_n_i && (cnt_r > waits_i);
    // Released lines change every cycle, so stale data never matches.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            last_r <= 16'h0000;
        else
            last_r <= bus_o;
    end
    assign bus_o = (!den_n_i && !dir_i) ? data_i : ~last_r;
endmodule

// File: test/test_cpu_local_bus_cycle_unit.sv
// Self-checking bench for the local bus cycle unit.
// Assumes the target model answers every read and acknowledge cycle.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module test_cpu_local_bus_cycle_unit;
    logic clk_i = 0;
    logic rst_i = 1;
    logic mode_strap_i = 1;
    logic req_i = 0;
    logic word_i = 0;
    logic last_i = 0;
    logic lock_prefix_i = 0;
    logic request_grant_i = 0;
    logic wait_active_i = 0;
    logic test_n_i = 1;
    logic queue_full_i = 0;
    logic intr_i = 0;
    logic int_enable_i = 0;
    logic [2:0] kind_i = 3'h0;
    logic [15:0] addr_i = 16'h0000;
    logic [15:0] wdata_i = 16'h0000;
    logic [15:0] tgt_data = 16'hA55A;
    logic [3:0] nw = 4'h0;
    logic ready_i, ack_o, done_o, vector_valid_o, lock_n_o, wait_done_o;
    logic request_grant_o, refetch_wait_o, address_latch_strobe_o;
    logic multiplexed_bus_oe_n_o, memory_or_io_select_o, read_strobe_n_o;
    logic store_strobe_n_o, interrupt_ack_n_o, high_byte_enable_n_o;
    logic transceiver_direction_o, transceiver_output_enable_n_o, ctl_oe_n_o;
    logic [15:0] rdata_o, multiplexed_bus_o, multiplexed_bus_i, tgt_bus;
    logic [9:0] vector_o;
    logic [2:0] cycle_status_o, st1, stp;
    logic [15:0] ale_bus;
    logic mio, mbad, wbad, drv;
    int cyc, strb, error_cnt = 0, checks = 0;
    cpu_local_bus_cycle_unit dut_u (.*);
    bus_target_model tgt_u (.clk_i(clk_i), .rst_i(rst_i), .waits_i(nw),
        .den_n_i(transceiver_output_enable_n_o),
        .dir_i(transceiver_direction_o), .data_i(tgt_data),
        .ready_o(ready_i), .bus_o(tgt_bus));
    // The device wins the wire whenever it enables its drivers.
    assign multiplexed_bus_i = multiplexed_bus_oe_n_o ? tgt_bus
                                                      : multiplexed_bus_o;
    // 25 MHz processor clock.
    always #20 clk_i = ~clk_i;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic do_reset(input logic strap);
        rst_i = 1;
        mode_strap_i = strap;
        repeat (8) @(negedge clk_i);
        rst_i = 0;
        repeat (2) @(negedge clk_i);
    endtask
    // One request held until taken, then watched to the last T4.
    task automatic op(input logic [2:0] k, input logic [15:0] a,
                      input logic w, input logic [15:0] d, input logic l);
        int n;
        int dn;
        {req_i, kind_i, addr_i, word_i} = {1'b1, k, a, w};
        {wdata_i, last_i} = {d, l};
        n = 0;
        #1;
        while (ack_o !== 1'b1 && n < 50) begin
            @(negedge clk_i);
            #1;
            n++;
        end
        @(negedge clk_i);
        req_i = 0;
        {cyc, strb, dn, mbad, wbad, drv} = '0;
        ale_bus = address_latch_strobe_o ? multiplexed_bus_o : '0;
        mio = memory_or_io_select_o;
        st1 = cycle_status_o;
        while (dn < (k == 3'h5 ? 2 : 1) && cyc < 60) begin
            if (memory_or_io_select_o !== mio) mbad = 1;
            if (!(read_strobe_n_o && store_strobe_n_o && interrupt_ack_n_o))
                strb++;
            if (!store_strobe_n_o && multiplexed_bus_o !== d) wbad = 1;
            if (cyc > 0 && multiplexed_bus_oe_n_o !== 1'b1) drv = 1;
            if (done_o === 1'b1) dn++;
            else stp = cycle_status_o;
            cyc++;
            if (dn < (k == 3'h5 ? 2 : 1)) @(negedge clk_i);
        end
    endtask
    // Reads with waits: odd byte, whole word, even byte.
    task automatic t_read();
        nw = 4'h2;
        op(3'h1, 16'h1235, 0, 16'h0000, 1);
        @(negedge clk_i);
        `CHK("ale bus", 16'h1235, ale_bus)
        `CHK("mio", 2'h1, {mbad, mio})
        `CHK("float", 1'b0, drv)
        `CHK("cycles", 6, cyc)
        `CHK("rd strobe", 4, strb)
        `CHK("odd bhe", 1'b0, high_byte_enable_n_o)
        `CHK("odd data", 8'hA5, rdata_o[7:0])
        op(3'h1, 16'h0040, 1, 16'h0000, 1);
        @(negedge clk_i);
        `CHK("word", 16'hA55A, rdata_o)
        op(3'h3, 16'h0042, 0, 16'h0000, 1);
        @(negedge clk_i);
        `CHK("even bhe", 1'b1, high_byte_enable_n_o)
        `CHK("even data", 8'h5A, rdata_o[7:0])
        $display("read test done");
    endtask
    // I/O word write with one wait state.
    task automatic t_write();
        nw = 4'h1;
        op(3'h4, 16'h0300, 1, 16'hBEEF, 1);
        `CHK("io mio", 2'h0, {mbad, mio})
        `CHK("wr data", 1'b0, wbad)
        `CHK("wr strobe", 3, strb)
        `CHK("wr t4 data", 16'hBEEF, multiplexed_bus_o)
        $display("write test done");
    endtask
    // Acknowledge pair returns type byte times four.
    task automatic t_ack();
        nw = 4'h0;
        tgt_data = 16'h3321;
        op(3'h5, 16'h0000, 0, 16'h0000, 1);
        @(negedge clk_i);
        `CHK("ack cycles", 8, cyc)
        `CHK("ack strobe", 4, strb)
        `CHK("ack float", 1'b0, drv)
        `CHK("vector", 10'h084, vector_o)
        $display("ack test done");
    endtask
    // Lock holds off a grant until the last locked cycle ends.
    task automatic t_lock();
        int n;
        lock_prefix_i = 1;
        @(negedge clk_i);
        lock_prefix_i = 0;
        request_grant_i = 1;
        @(negedge clk_i);
        `CHK("lock on", 1'b0, lock_n_o)
        op(3'h1, 16'h0010, 1, 16'h0000, 0);
        op(3'h2, 16'h0010, 1, 16'h1234, 1);
        `CHK("no grant", 1'b0, request_grant_o)
        n = 0;
        while (request_grant_o !== 1'b1 && n < 10) begin
            @(negedge clk_i);
            n++;
        end
        `CHK("lock off", 1'b1, lock_n_o)
        `CHK("grant", 1'b1, request_grant_o)
        request_grant_i = 0;
        repeat (3) @(negedge clk_i);
        $display("lock test done");
    endtask
    // Wait on test pin, full queue, hold and interrupt on return.
    task automatic t_wait();
        int n;
        int seen;
        {wait_active_i, queue_full_i, req_i, kind_i} = 6'h38;
        seen = 0;
        repeat (4) begin
            @(negedge clk_i);
            seen += (ack_o === 1'b1);
        end
        req_i = 0;
        `CHK("no fetch", 0, seen)
        `CHK("waiting", 1'b0, wait_done_o)
        {request_grant_i, intr_i, int_enable_i} = 3'b111;
        repeat (4) @(negedge clk_i);
        `CHK("float ctl", 1'b1, ctl_oe_n_o)
        request_grant_i = 0;
        n = 0;
        seen = 0;
        while (seen == 0 && n < 40) begin
            @(negedge clk_i);
            seen = (refetch_wait_o === 1'b1);
            n++;
        end
        `CHK("refetch", 1, seen)
        {intr_i, test_n_i} = 2'b00;
        #1;
        `CHK("wait end", 1'b1, wait_done_o)
        {wait_active_i, queue_full_i, test_n_i} = 3'b001;
        $display("wait test done");
    endtask
    // Maximum mode: status per kind, no strobes, inactive before T4.
    task automatic t_max();
        logic [2:0] sx [7] = '{3'h4, 3'h5, 3'h6, 3'h1, 3'h2, 3'h0, 3'h3};
        do_reset(0);
        for (int k = 0; k < 7; k++) begin
            op(k[2:0], 16'h0020, 1, 16'h0F0F, 1);
            `CHK("status", sx[k], st1)
            `CHK("no strobe", 0, strb)
            if (k != 6) `CHK("inactive", 3'h7, stp)
            @(negedge clk_i);
        end
        $display("max mode test done");
    endtask
    // Watchdog well above the whole run.
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        do_reset(1);
        t_read();
        t_write();
        t_ack();
        t_lock();
        t_wait();
        t_max();
        end_of_test();
    end
endmodule
